/* File: core/rtcc_core.sv */
// rtc core: bcd timekeeping, 32-byte register space, two-wire bus slave
// assumes osc_32k from a free oscillator, scl/sda from pins, supply_ok from power sense
//
// Operation
// - time and calendar kept in eight bcd bytes
// - fields cover century to hundredths, hours counted 0 to 23
// - date rolls over at 28, 29, 30 or 31 days automatically
// - seventeen control and status bytes are provided
// - seven user bytes readable and writable, kept on battery
// - address pointer advances after every data byte, read or write
// - registers reached over two-wire serial bus, host is master
// - timekeeping derived from the 32.768 kHz oscillator
// - supply failure moves to battery and the clock keeps running
// - access opens with start and address d0h or d1h only
// - sequential bytes follow fixed order from sub-second to user storage
// - below reset trip threshold abort access, clear pointer, ignore bus
`timescale 1ns/1ps
module rtcc_core
   import rtcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic osc_32k,
   input wire logic supply_ok,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic on_battery
);
   // --------------------------------------------------------------
   // synchronisers
   // --------------------------------------------------------------
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [1:0] bus_old_reg;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= 4'hF;
         s2_reg <= 4'hF;
         bus_old_reg <= 2'h3;
      end
      else
      begin
         s1_reg <= {osc_32k, supply_ok, scl_in, sda_in};
         s2_reg <= s1_reg;
         bus_old_reg <= s2_reg[1:0];
      end
   end
   wire scl = s2_reg[1];
   wire sda = s2_reg[0];
   wire pwr_ok = s2_reg[2];
   wire osc = s2_reg[3];
   assign on_battery = !pwr_ok;
   wire scl_rise = scl && !bus_old_reg[1];
   wire scl_fall = !scl && bus_old_reg[1];
   wire start_c = scl && bus_old_reg[1] && bus_old_reg[0] && !sda;
   wire stop_c = scl && bus_old_reg[1] && !bus_old_reg[0] && sda;

   // --------------------------------------------------------------
   // timebase: 32768 oscillator edges give 100 ticks per second
   // --------------------------------------------------------------
   // fractional accumulator: +100 per edge, tick at 32768; avoids drift
   logic osc_old_reg;
   logic [15:0] acc_reg;
   wire osc_rise = osc && !osc_old_reg;
   wire [16:0] acc_sum = {1'b0, acc_reg} + 17'(`RTCC_TICK_HZ);
   wire tick = osc_rise && (acc_sum >= 17'(`RTCC_OSC_KHZ_X1000));
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_old_reg <= 1'b1; // matches the preset sync flop, so no false edge after reset
         acc_reg <= 16'h0000;
      end
      else
      begin
         osc_old_reg <= osc;
         if (osc_rise)
            acc_reg <= tick ? 16'(acc_sum - 17'(`RTCC_OSC_KHZ_X1000)) : acc_sum[15:0];
      end
   end

   // --------------------------------------------------------------
   // register space
   // --------------------------------------------------------------
   rtcc_byte_t mem_reg [0:`RTCC_NUM_BYTES-1];
   rtcc_byte_t mem_next [0:`RTCC_NUM_BYTES-1];
   logic [4:0] ptr_reg;
   logic wr_en;
   rtcc_byte_t wr_data;

   // month length from bcd month and year; year divisible by four is leap
   wire [7:0] month = mem_reg[`RTCC_OFF_MONTH];
   wire [7:0] year = mem_reg[`RTCC_OFF_YEAR];
   wire leap = (year[4] ? (year[1:0] == 2'h2) : (year[1:0] == 2'h0));
   wire thirty = (month == 8'h04) || (month == 8'h06) || (month == 8'h09) || (month == 8'h11);
   wire [7:0] dim = (month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
      thirty ? 8'h30 : 8'h31;

   // counting chain: subsec, sec, min, hour, day, date, month, year, century
   logic [7:0] cnt_val [0:8];
   logic [7:0] cnt_last [0:8];
   logic [7:0] cnt_first [0:8];
   logic [7:0] cnt_nxt [0:8];
   logic [8:0] cnt_wrap;
   logic [9:0] carry;
   assign carry[0] = tick;
   assign cnt_val[0] = mem_reg[0];
   assign cnt_val[1] = {1'b0, mem_reg[1][6:0]};
   assign cnt_val[2] = {1'b0, mem_reg[2][6:0]};
   assign cnt_val[3] = {2'h0, mem_reg[3][5:0]};
   assign cnt_val[4] = {5'h00, mem_reg[4][2:0]};
   assign cnt_val[5] = {2'h0, mem_reg[5][5:0]};
   assign cnt_val[6] = {3'h0, mem_reg[6][4:0]};
   assign cnt_val[7] = mem_reg[7];
   assign cnt_val[8] = {6'h00, mem_reg[3][7:6]};
   assign cnt_last[0] = 8'h99;
   assign cnt_last[1] = 8'h59;
   assign cnt_last[2] = 8'h59;
   assign cnt_last[3] = 8'h23;
   assign cnt_last[4] = 8'h07;
   assign cnt_last[5] = dim;
   assign cnt_last[6] = 8'h12;
   assign cnt_last[7] = 8'h99;
   assign cnt_last[8] = 8'h03;
   assign cnt_first[0] = 8'h00;
   assign cnt_first[1] = 8'h00;
   assign cnt_first[2] = 8'h00;
   assign cnt_first[3] = 8'h00;
   assign cnt_first[4] = 8'h01;
   assign cnt_first[5] = 8'h01;
   assign cnt_first[6] = 8'h01;
   assign cnt_first[7] = 8'h00;
   assign cnt_first[8] = 8'h00;
   // day of week steps with the date carry, not on its own wrap
   assign carry[4] = carry[3] && cnt_wrap[3];
   assign carry[5] = carry[4];
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++)
      begin : g_cnt
         rtcc_bcd_digit u_dig (
            .value(cnt_val[gi]),
            .last(cnt_last[gi]),
            .first(cnt_first[gi]),
            .next_value(cnt_nxt[gi]),
            .wrap(cnt_wrap[gi])
         );
         if (gi != 3 && gi != 4)
         begin : g_car
            assign carry[gi+1] = carry[gi] && cnt_wrap[gi];
         end
      end
   endgenerate

   // next register contents: bus write takes priority over counting
   always_comb
   begin
      for (int i = 0; i < `RTCC_NUM_BYTES; i++)
         mem_next[i] = mem_reg[i];
      if (carry[0])
         mem_next[0] = cnt_nxt[0];
      if (carry[1])
         mem_next[1] = {mem_reg[1][7], cnt_nxt[1][6:0]};
      if (carry[2])
         mem_next[2] = {mem_reg[2][7], cnt_nxt[2][6:0]};
      if (carry[3])
         mem_next[3][5:0] = cnt_nxt[3][5:0];
      if (carry[8])
         mem_next[3][7:6] = cnt_nxt[8][1:0];
      if (carry[4])
         mem_next[4] = {mem_reg[4][7:3], cnt_nxt[4][2:0]};
      if (carry[5])
         mem_next[5] = {mem_reg[5][7:6], cnt_nxt[5][5:0]};
      if (carry[6])
         mem_next[6] = {mem_reg[6][7:5], cnt_nxt[6][4:0]};
      if (carry[7])
         mem_next[7] = cnt_nxt[7];
      if (wr_en)
         mem_next[ptr_reg] = wr_data;
   end

   // timekeeping runs regardless of supply state
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < `RTCC_NUM_BYTES; i++)
            mem_reg[i] <= 8'h00;
         mem_reg[`RTCC_OFF_DAY] <= `RTCC_RST_DAY;
         mem_reg[`RTCC_OFF_DATE] <= `RTCC_RST_DATE;
         mem_reg[`RTCC_OFF_MONTH] <= `RTCC_RST_MONTH;
      end
      else
      begin
         for (int i = 0; i < `RTCC_NUM_BYTES; i++)
            mem_reg[i] <= mem_next[i];
      end
   end

   // --------------------------------------------------------------
   // two-wire slave
   // --------------------------------------------------------------
   rtcc_state_t st_reg;
   logic [7:0] sh_reg;
   logic [3:0] bit_reg;
   logic first_reg;
   logic rw_reg;
   logic drive_reg;
   wire addr_hit = (sh_reg[7:1] == `RTCC_BUS_ADDR);
   wire [4:0] ptr_inc = (ptr_reg == `RTCC_PTR_LAST) ? 5'h00 : ptr_reg + 5'h01;
   assign wr_en = pwr_ok && (st_reg == RTCC_WR) && scl_fall && (bit_reg == 4'h8) && !first_reg;
   assign wr_data = sh_reg;
   assign sda_out = 1'b0;
   assign sda_oe = drive_reg;

   // bit counter counts rising edges in address and write states, falling edges in read; actions fall on the falling edge after bit 8
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= RTCC_IDLE;
         sh_reg <= 8'h00;
         bit_reg <= 4'h0;
         first_reg <= 1'b0;
         rw_reg <= 1'b0;
         drive_reg <= 1'b0;
         ptr_reg <= 5'h00;
      end
      else if (!pwr_ok)
      begin
         st_reg <= RTCC_IDLE;
         drive_reg <= 1'b0;
         ptr_reg <= 5'h00;
         bit_reg <= 4'h0;
      end
      else if (start_c)
      begin
         st_reg <= RTCC_ADDR;
         bit_reg <= 4'h0;
         drive_reg <= 1'b0;
      end
      else if (stop_c)
      begin
         st_reg <= RTCC_IDLE;
         drive_reg <= 1'b0;
      end
      else
      begin
         case (st_reg)
            RTCC_IDLE:
               drive_reg <= 1'b0;
            RTCC_ADDR, RTCC_WR:
            begin
               if (scl_rise)
               begin
                  sh_reg <= {sh_reg[6:0], sda};
                  bit_reg <= bit_reg + 4'h1;
               end
               else if (scl_fall && bit_reg == 4'h8)
               begin
                  if (st_reg == RTCC_ADDR)
                  begin
                     if (addr_hit)
                     begin
                        rw_reg <= sh_reg[0];
                        first_reg <= 1'b1;
                        drive_reg <= 1'b1;
                        st_reg <= RTCC_ADDR_ACK;
                     end
                     else
                        st_reg <= RTCC_IDLE;
                  end
                  else
                  begin
                     if (first_reg)
                        ptr_reg <= sh_reg[4:0];
                     else
                        ptr_reg <= ptr_inc;
                     first_reg <= 1'b0;
                     drive_reg <= 1'b1;
                     st_reg <= RTCC_WR_ACK;
                  end
               end
            end
            RTCC_ADDR_ACK, RTCC_WR_ACK:
               if (scl_fall)
               begin
                  bit_reg <= 4'h0;
                  if (st_reg == RTCC_ADDR_ACK && rw_reg)
                  begin
                     sh_reg <= mem_reg[ptr_reg];
                     drive_reg <= !mem_reg[ptr_reg][7];
                     st_reg <= RTCC_RD;
                  end
                  else
                  begin
                     drive_reg <= 1'b0;
                     st_reg <= RTCC_WR;
                  end
               end
            RTCC_RD:
               if (scl_fall)
               begin
                  if (bit_reg == 4'h7)
                  begin
                     drive_reg <= 1'b0;
                     ptr_reg <= ptr_inc;
                     st_reg <= RTCC_RD_ACK;
                  end
                  else
                  begin
                     sh_reg <= {sh_reg[6:0], 1'b0};
                     drive_reg <= !sh_reg[6];
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
            RTCC_RD_ACK:
               if (scl_rise)
               begin
                  // host nack ends the read; ack continues with the next byte
                  if (sda)
                     st_reg <= RTCC_IDLE;
                  else
                     bit_reg <= 4'h0;
               end
               else if (scl_fall)
               begin
                  sh_reg <= mem_reg[ptr_reg];
                  drive_reg <= !mem_reg[ptr_reg][7];
                  st_reg <= RTCC_RD;
               end
            default:
               st_reg <= RTCC_IDLE;
         endcase
      end
   end
endmodule

/* File: core/rtcc_map.svh */
// register offsets, bus address, reset values and timing counts for the rtc core
// assumes inclusion by bare name from the package file
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH
`define RTCC_BUS_ADDR 7'h68
`define RTCC_NUM_BYTES 32
`define RTCC_PTR_LAST 5'h1F
`define RTCC_OFF_SUBSEC 5'h00
`define RTCC_OFF_SEC 5'h01
`define RTCC_OFF_MIN 5'h02
`define RTCC_OFF_HOUR 5'h03
`define RTCC_OFF_DAY 5'h04
`define RTCC_OFF_DATE 5'h05
`define RTCC_OFF_MONTH 5'h06
`define RTCC_OFF_YEAR 5'h07
`define RTCC_OFF_CTRL_FIRST 5'h08
`define RTCC_OFF_CTRL_LAST 5'h18
`define RTCC_OFF_SRAM_FIRST 5'h19
`define RTCC_OSC_KHZ_X1000 32768
`define RTCC_CLK_HZ 20000000
`define RTCC_TICK_HZ 100
`define RTCC_RST_DATE 8'h01
`define RTCC_RST_MONTH 8'h01
`define RTCC_RST_DAY 8'h01
`endif

/* File: core/rtcc_pkg.sv */
// types shared by the rtc core files
// assumes rtcc_map.svh is on the include path
`include "rtcc_map.svh"
package rtcc_pkg;
   typedef enum logic [2:0] {
      RTCC_IDLE,
      RTCC_ADDR,
      RTCC_ADDR_ACK,
      RTCC_WR,
      RTCC_WR_ACK,
      RTCC_RD,
      RTCC_RD_ACK
   } rtcc_state_t;
   typedef logic [7:0] rtcc_byte_t;
endpackage

/* File: core/rtcc_bcd_digit.sv */
// one bcd counter field with a programmable rollover value
`timescale 1ns/1ps
module rtcc_bcd_digit
   import rtcc_pkg::*;
(
   input wire logic [7:0] value,
   input wire logic [7:0] last,
   input wire logic [7:0] first,
   output logic [7:0] next_value,
   output logic wrap
);
   // --------------------------------------------------------------
   // increment
   // --------------------------------------------------------------
   // wraps to first after last; low digit carries at 9
   assign wrap = (value >= last);
   assign next_value = wrap ? first :
      (value[3:0] >= 4'h9) ? {value[7:4] + 4'h1, 4'h0} : {value[7:4], value[3:0] + 4'h1};
endmodule

/* File: verification/rtcc_core_asserts.sv */
// pin checker for the rtc core: supply sensing and sda drive timing
// assumes one clock domain and a bind onto rtcc_core
`timescale 1ns/1ps
module rtcc_core_asserts
   import rtcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic supply_ok,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic on_battery
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // core starts pulling data low
   sequence s_drive;
      $rose(sda_oe);
   endsequence
   sequence s_lost;
      $fell(supply_ok);
   endsequence
   // two sync flops, so three low samples are enough
   AST_BATT_ON: assert property ((!supply_ok)[*3] |-> on_battery)
      else $error("no battery flag");
   AST_BATT_OFF: assert property (supply_ok[*3] |-> !on_battery)
      else $error("stale battery flag");
   AST_QUIET: assert property (on_battery[*3] |-> !sda_oe)
      else $error("bus driven on battery");
   AST_ABORT: assert property (s_lost |-> ##[1:8] !sda_oe)
      else $error("access not aborted");
   AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
      else $error("sda driven high");
   // data may only move while the bus clock is low
   AST_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved with scl high");
   AST_HOLD: assert property (s_drive |-> sda_oe[*8])
      else $error("sda bit too short");
   AST_LOW_AFTER: assert property (s_drive |-> (!scl_in)[*3])
      else $error("sda drive late");
endmodule
bind rtcc_core rtcc_core_asserts u_chk (.clk(clk), .rstn(rstn), .supply_ok(supply_ok),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .on_battery(on_battery));

/* File: verification/rtcc_i2c_host.sv */
// two-wire bus master model driving the core's clock and data pins
// assumes a pull-up on data; the bench forms the wired data level
`timescale 1ns/1ps
module rtcc_i2c_host
   import rtcc_pkg::*;
#(
   parameter int HALF = 8
)
(
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_m
);
   // ----
   // bus phases, each held HALF clocks
   // ----
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // change just after an edge, then hold well past the core's sync delay
   task automatic drive(input logic c, input logic s);
      @(posedge clk);
      scl <= c;
      sda_m <= s;
      repeat (HALF - 1) @(posedge clk);
   endtask
   // data changes only while the clock is low
   task automatic bit_io(input logic b, output logic got);
      drive(1'b0, sda_m);
      drive(1'b0, b);
      drive(1'b1, b);
      @(negedge clk);
      got = sda_line;
   endtask
   task automatic bus_start();
      drive(1'b0, sda_m);
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
   endtask
   task automatic bus_stop();
      drive(1'b0, sda_m);
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
   endtask
   // msb first; ack is high when the core pulled the ninth bit low
   task automatic put_byte(input rtcc_byte_t v, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_io(v[i], g);
      bit_io(1'b1, g);
      ack = ~g;
   endtask
   task automatic get_byte(input logic ack, output rtcc_byte_t v);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, v[i]);
      bit_io(~ack, g);
   endtask
endmodule

/* File: verification/rtc_calendar_register_core_tb_top.sv */
// bench for the rtc core: reset values, rollover, storage, address, supply loss
// assumes the host model and the bound checker
`timescale 1ns/1ps
module rtc_calendar_register_core_tb_top;
   import rtcc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic osc_32k = 1'b0;
   logic supply_ok = 1'b1;
   logic osc_run = 1'b0;
   logic [1:0] osc_div = 2'h0;
   logic sda_out, sda_oe, on_battery, scl, sda_m, ack;
   wire sda_line = sda_m & ~(sda_oe & ~sda_out);
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   rtcc_byte_t mem [32];
   rtcc_byte_t got;
   logic [15:0] dm;
   logic [23:0] cal [4] = '{24'h280223, 24'h280224, 24'h300999, 24'h311299};
   rtcc_core dut (.clk(clk), .rstn(rstn), .osc_32k(osc_32k), .supply_ok(supply_ok),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .on_battery(on_battery));
   rtcc_i2c_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
   // ----
   // clock, fast oscillator and hang guard
   // ----
   initial
   begin
      forever #25 clk = ~clk;
   end
   // oscillator sped up so one tick lands within a few thousand clocks
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      osc_div <= osc_div + 2'h1;
      if (osc_run && osc_div == 2'h3)
         osc_32k <= ~osc_32k;
      if (cycles == 60000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h got %h", what, exp, seen);
      end
   endtask
   function automatic rtcc_byte_t bcd_rand();
      return {4'($urandom % 10), 4'($urandom % 10)};
   endfunction
   // expected {date, month} one day on; years divisible by four are leap
   function automatic logic [15:0] next_day(input logic [23:0] c);
      int yv;
      logic [7:0] last;
      yv = c[7:4] * 10 + c[3:0];
      if (c[15:8] == 8'h02)
         last = (yv % 4 == 0) ? 8'h29 : 8'h28;
      else if (c[15:8] inside {8'h04, 8'h06, 8'h09, 8'h11})
         last = 8'h30;
      else
         last = 8'h31;
      if (c[23:16] != last)
         return {c[23:16] + 8'h01, c[15:8]};
      if (c[15:8] == 8'h12)
         return 16'h0101;
      return {8'h01, (c[15:8] == 8'h09) ? 8'h10 : c[15:8] + 8'h01};
   endfunction
   task automatic load(input logic [63:0] t);
      for (int j = 0; j < 8; j++)
         mem[j] = t[63 - 8 * j -: 8];
   endtask
   // address phase; leaves the bus open after the pointer byte
   task automatic set_ptr(input rtcc_byte_t p);
      host.bus_start();
      host.put_byte(8'hD0, ack);
      check("addr ack", 8'h01, {7'h00, ack});
      host.put_byte(p, ack);
      check("ptr ack", 8'h01, {7'h00, ack});
   endtask
   task automatic write_run(input rtcc_byte_t p, input int n);
      set_ptr(p);
      for (int i = 0; i < n; i++)
      begin
         host.put_byte(mem[(p + i) % 32], ack);
         check("data ack", 8'h01, {7'h00, ack});
      end
      host.bus_stop();
   endtask
   task automatic read_run(input rtcc_byte_t p, input int n, input string what);
      set_ptr(p);
      host.bus_start();
      host.put_byte(8'hD1, ack);
      check("read ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < n; i++)
      begin
         host.get_byte(i < n - 1, got);
         check(what, mem[(p + i) % 32], got);
      end
      host.bus_stop();
   endtask
   // ----
   // main sequence
   // ----
   initial
   begin
      void'($urandom(32'hCD3345A8));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      load(64'h0000000001010100);
      read_run(8'h00, 8, "reset map");
      $display("reset map test done");
      for (int k = 0; k < 4; k++)
      begin
         if (k > 1)
            cal[k][7:0] = bcd_rand();
         load({32'h99595923, 8'h01, cal[k]});
         write_run(8'h00, 8);
         osc_run <= 1'b1;
         repeat (3200) @(posedge clk);
         osc_run <= 1'b0;
         dm = next_day(cal[k]);
         // one tick from 23:59:59.99 clears the time, steps the day; century on year 99
         load({24'h000000, (k == 3 && cal[k][7:0] == 8'h99) ? 8'h40 : 8'h00, 8'h02, dm, 8'h00});
         read_run(8'h00, 7, "calendar");
      end
      $display("calendar test done");
      for (int i = 8; i < 32; i++)
         mem[i] = rtcc_byte_t'($urandom);
      mem[0] = bcd_rand();
      write_run(8'h08, 25);
      read_run(8'h08, 25, "storage");
      $display("storage test done");
      for (int i = 0; i < 4; i++)
      begin
         host.bus_start();
         host.put_byte((i == 0) ? 8'hD2 : {7'($urandom % 104), 1'($urandom)}, ack);
         check("foreign ack", 8'h00, {7'h00, ack});
         host.bus_stop();
      end
      $display("address test done");
      set_ptr(8'h19);
      host.drive(1'b0, 1'b1);
      supply_ok <= 1'b0;
      repeat (8) @(negedge clk);
      check("battery", 8'h01, {7'h00, on_battery});
      host.put_byte(8'h5A, ack);
      check("ignored ack", 8'h00, {7'h00, ack});
      host.bus_stop();
      supply_ok <= 1'b1;
      repeat (8) @(posedge clk);
      host.bus_start();
      host.put_byte(8'hD1, ack);
      host.get_byte(1'b0, got);
      host.bus_stop();
      check("cleared ptr", mem[0], got);
      read_run(8'h19, 1, "kept sram");
      $display("supply test done");
      end_of_test();
   end
endmodule
